// ---- inc/ber_pkg.sv ----
// Register map, field layout, thresholds and types of the bit error rate tester
package ber_pkg;
	// ==========================================================
	// Widths
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int NUM_EV = 6;
	localparam int LEN_W = 5;
	typedef logic [ADDR_W-1:0] ber_addr_t;
	typedef logic [DATA_W-1:0] ber_byte_t;

	// ==========================================================
	// Register offsets; wide registers use consecutive bytes
	localparam ber_addr_t A_SOFT_RESET = 13'h00f6;
	localparam ber_addr_t A_GIRQ_STATUS = 13'h00fa;
	localparam ber_addr_t A_GIRQ_MASK = 13'h00fd;
	localparam ber_addr_t A_RX_PORT_CTRL = 13'h008a;
	localparam ber_addr_t A_RX_BIT_SUPP = 13'h008b;
	localparam ber_addr_t A_RX_CH_SEL = 13'h00d4;
	localparam ber_addr_t A_TX_PORT_CTRL = 13'h018a;
	localparam ber_addr_t A_TX_BIT_SUPP = 13'h018b;
	localparam ber_addr_t A_TX_CH_SEL = 13'h01d4;
	localparam ber_addr_t A_ALT_COUNT = 13'h1100;
	localparam ber_addr_t A_PATTERN = 13'h1101;
	localparam ber_addr_t A_CTRL_ONE = 13'h1105;
	localparam ber_addr_t A_CTRL_TWO = 13'h1106;
	localparam ber_addr_t A_BIT_COUNT = 13'h1107;
	localparam ber_addr_t A_ERR_COUNT = 13'h110b;
	localparam ber_addr_t A_LATCHED = 13'h110e;
	localparam ber_addr_t A_STAT_MASK = 13'h110f;
	localparam ber_addr_t SPAN3 = 13'h0003;
	localparam ber_addr_t SPAN4 = 13'h0004;
	localparam ber_addr_t SPAN7 = 13'h0007;

	// ==========================================================
	// Field positions
	localparam int PORT_EN_BIT = 0;
	localparam int SOFT_RST_BIT = 0;
	localparam int GIRQ_BIT = 0;
	localparam int LC_BIT = 0;
	localparam int MODE_LSB = 2;
	localparam int MODE_W = 3;
	localparam int EV_SYNC = 0;
	localparam int EV_ZEROS = 1;
	localparam int EV_ONES = 2;
	localparam int EV_ERR_OVF = 3;
	localparam int EV_BIT_OVF = 4;
	localparam int EV_BIT_ERR = 5;

	// ==========================================================
	// Reset values and thresholds (in checked bits)
	localparam logic [31:0] RST_PATTERN = 32'hffffffff;
	localparam ber_byte_t RST_CTRL_TWO = 8'h1f;
	localparam ber_byte_t RST_ZERO = 8'h00;
	localparam int SYNC_RUN = 32;
	localparam int LOSS_WIN = 32;
	localparam int LOSS_ERRS = 4;
	localparam int STUCK_RUN = 32;
	localparam int QRSS_ZRUN = 14;

	// ==========================================================
	// Types
	typedef enum logic [MODE_W-1:0] {
		M_PRBS7, M_PRBS9, M_PRBS11, M_PRBS15, M_QRSS, M_REPEAT, M_ALT_WORD, M_DALY
	} ber_mode_e;
	typedef enum logic {S_HUNT, S_LOCKED} ber_sync_e;
	typedef struct packed {
		logic strobe;
		logic [4:0] slot;
		logic [2:0] pos;
		logic data;
	} ber_slot_bit_s;
endpackage

// ---- rtl/ber_pattern_engine.sv ----
// Pattern engine: pseudorandom, repeating, alternating-word and fixed-word sources
`timescale 1ns/1ps
module ber_pattern_engine #(
	parameter int PAT_W = 32
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Control
	input wire logic restart_i,
	input wire logic advance_i,
	input wire logic load_i,
	input wire logic load_bit_i,
	input wire ber_pkg::ber_mode_e mode_i,
	input wire logic [PAT_W-1:0] pattern_i,
	input wire logic [ber_pkg::LEN_W-1:0] len_m1_i,
	input wire logic [7:0] alt_count_i,
	// Current pattern bit
	output logic bit_o
);
	import ber_pkg::*;
	localparam logic [LEN_W-1:0] HALF_LAST = LEN_W'(PAT_W / 2 - 1);
	localparam logic [LEN_W-1:0] FULL_LAST = LEN_W'(PAT_W - 1);
	logic [PAT_W-1:0] sh_reg;
	logic [LEN_W-1:0] ptr_reg;
	logic [7:0] wcnt_reg;
	logic sel_reg;
	logic fb;
	logic [LEN_W-1:0] last;

	generate
		if (PAT_W != 32) begin : g_chk
			$error("pattern width must be 32");
		end
	endgenerate

	// ==========================================================
	// Feedback of the selected polynomial
	always_comb begin
		case (mode_i)
			M_PRBS7: fb = sh_reg[6] ^ sh_reg[5];
			M_PRBS9: fb = sh_reg[8] ^ sh_reg[4];
			M_PRBS11: fb = sh_reg[10] ^ sh_reg[8];
			M_PRBS15: fb = sh_reg[14] ^ sh_reg[13];
			M_QRSS: fb = sh_reg[19] ^ sh_reg[16];
			default: fb = 1'b0;
		endcase
	end

	// Word length and output bit; index 0 leaves first
	always_comb begin
		case (mode_i)
			M_REPEAT: last = len_m1_i;
			M_ALT_WORD: last = HALF_LAST;
			default: last = FULL_LAST;
		endcase
		case (mode_i)
			M_REPEAT, M_DALY: bit_o = pattern_i[ptr_reg];
			M_ALT_WORD: bit_o = pattern_i[{sel_reg, ptr_reg[LEN_W-2:0]}];
			M_QRSS: bit_o = fb | ~|sh_reg[QRSS_ZRUN-1:0];
			default: bit_o = fb;
		endcase
	end

	// Shift register; a checker that hunts a pseudorandom pattern feeds received bits in
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			sh_reg <= RST_PATTERN;
		else if (restart_i)
			sh_reg <= pattern_i;
		else if (advance_i)
			sh_reg <= {sh_reg[PAT_W-2:0], load_i ? load_bit_i : fb};
	end

	// Bit pointer and alternating-word counter; count 0 means 256 words
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || restart_i) begin
			ptr_reg <= '0;
			wcnt_reg <= '0;
			sel_reg <= 1'b0;
		end else if (advance_i) begin
			if (ptr_reg == last) begin
				ptr_reg <= '0;
				if (mode_i == M_ALT_WORD) begin
					if (wcnt_reg == alt_count_i - 8'h01) begin
						wcnt_reg <= '0;
						sel_reg <= ~sel_reg;
					end else
						wcnt_reg <= wcnt_reg + 8'h01;
				end
			end else
				ptr_reg <= ptr_reg + 1'b1;
		end
	end

	// ==========================================================
	// Checks
	property p_rep_wrap;
		@(posedge ref_clk_i) disable iff (reset_i)
		mode_i == M_REPEAT && advance_i && !restart_i && ptr_reg == len_m1_i |=> ptr_reg == '0;
	endproperty
	a_rep_wrap: assert property (p_rep_wrap) else $error("repeat pointer did not wrap");
	property p_alt_flip;
		@(posedge ref_clk_i) disable iff (reset_i)
		$changed(sel_reg) && !$past(restart_i) |-> $past(ptr_reg) == HALF_LAST;
	endproperty
	a_alt_flip: assert property (p_alt_flip) else $error("word flipped mid-word");
endmodule

// ---- rtl/ber_tester.sv ----
// Bit error rate tester: pattern insertion, checking, counters and status
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module ber_tester #(
	parameter int BIT_CNT_W = 32,
	parameter int ERR_CNT_W = 24
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port
	input wire ber_pkg::ber_addr_t addr_i,
	input wire ber_pkg::ber_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output ber_pkg::ber_byte_t rdata_o,
	// Framer transmit path
	input wire ber_pkg::ber_slot_bit_s tx_in_i,
	output ber_pkg::ber_slot_bit_s tx_out_o,
	// Framer receive path
	input wire ber_pkg::ber_slot_bit_s rx_in_i,
	// Status
	output logic rx_in_sync_o,
	output logic global_event_o
);
	import ber_pkg::*;
	localparam logic [BIT_CNT_W-1:0] BIT_MAX = '1;
	localparam logic [ERR_CNT_W-1:0] ERR_MAX = '1;
	localparam logic [BIT_CNT_W-1:0] BIT_NEAR = BIT_MAX - 1'b1;
	localparam logic [ERR_CNT_W-1:0] ERR_NEAR = ERR_MAX - 1'b1;
	localparam logic [5:0] SYNC_LAST = 6'(SYNC_RUN - 1);
	localparam logic [5:0] WIN_LAST = 6'(LOSS_WIN - 1);
	localparam logic [5:0] LOSS_LAST = 6'(LOSS_ERRS - 1);
	localparam logic [5:0] STUCK_LAST = 6'(STUCK_RUN - 1);
	localparam logic [5:0] STUCK_FULL = 6'(STUCK_RUN);

	generate
		if (BIT_CNT_W < 1 || BIT_CNT_W > 32 || ERR_CNT_W < 1 || ERR_CNT_W > 24) begin : g_chk
			$error("counter widths out of range");
		end
	endgenerate

	// ==========================================================
	// Register storage
	ber_byte_t soft_rst_reg, girq_mask_reg, alt_reg, ctrl1_reg, ctrl2_reg;
	ber_byte_t rx_ctrl_reg, rx_supp_reg, tx_ctrl_reg, tx_supp_reg;
	logic [31:0] pat_reg, rx_sel_reg, tx_sel_reg;
	logic [NUM_EV-1:0] stat_mask_reg, latched_reg, ev, clr_v, keep_v;
	logic [BIT_CNT_W-1:0] bit_cnt_reg, bit_snap_reg;
	logic [ERR_CNT_W-1:0] err_cnt_reg, err_snap_reg;
	logic [31:0] bit_rd, err_rd;
	logic restart_reg, lc_prev_reg, last_bit_reg;
	logic [5:0] run_reg, win_reg, loss_reg, stuck_reg;
	ber_sync_e sync_reg, sync_next;
	ber_mode_e mode;
	logic tst_rst, eng_restart, tx_pick, tx_bit, rx_pick, rx_bit, rx_err;
	logic lfsr_mode, locked, rx_adv, rx_load, lc_tog, cnt_bit, cnt_err;
	logic stuck_hit, gstat;

	function automatic logic hit(input ber_addr_t base, input ber_addr_t span);
		return (addr_i >= base) && (addr_i < base + span);
	endfunction
	function automatic logic [1:0] byte_idx(input ber_addr_t base);
		ber_addr_t d;
		d = addr_i - base;
		return d[1:0];
	endfunction

	// ==========================================================
	// Register writes; counters and status are read-only here
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			soft_rst_reg <= RST_ZERO;
			girq_mask_reg <= RST_ZERO;
			rx_ctrl_reg <= RST_ZERO;
			rx_supp_reg <= RST_ZERO;
			tx_ctrl_reg <= RST_ZERO;
			tx_supp_reg <= RST_ZERO;
			alt_reg <= RST_ZERO;
			ctrl1_reg <= RST_ZERO;
			ctrl2_reg <= RST_CTRL_TWO;
			stat_mask_reg <= '0;
			pat_reg <= RST_PATTERN;
			rx_sel_reg <= '0;
			tx_sel_reg <= '0;
		end else if (wr_i) begin
			case (addr_i)
				A_SOFT_RESET: soft_rst_reg <= wdata_i;
				A_GIRQ_MASK: girq_mask_reg <= wdata_i;
				A_RX_PORT_CTRL: rx_ctrl_reg <= wdata_i;
				A_RX_BIT_SUPP: rx_supp_reg <= wdata_i;
				A_TX_PORT_CTRL: tx_ctrl_reg <= wdata_i;
				A_TX_BIT_SUPP: tx_supp_reg <= wdata_i;
				A_ALT_COUNT: alt_reg <= wdata_i;
				A_CTRL_ONE: ctrl1_reg <= wdata_i;
				A_CTRL_TWO: ctrl2_reg <= wdata_i;
				A_STAT_MASK: stat_mask_reg <= wdata_i[NUM_EV-1:0];
				default: ;
			endcase
			if (hit(A_PATTERN, SPAN4))
				pat_reg[{byte_idx(A_PATTERN), 3'b000} +: DATA_W] <= wdata_i;
			if (hit(A_RX_CH_SEL, SPAN4))
				rx_sel_reg[{byte_idx(A_RX_CH_SEL), 3'b000} +: DATA_W] <= wdata_i;
			if (hit(A_TX_CH_SEL, SPAN4))
				tx_sel_reg[{byte_idx(A_TX_CH_SEL), 3'b000} +: DATA_W] <= wdata_i;
		end
	end

	// Pattern setup writes restart both engines one cycle later, once the byte has landed
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			restart_reg <= 1'b0;
		else
			restart_reg <= wr_i && hit(A_ALT_COUNT, SPAN7);
	end

	assign tst_rst = reset_i || soft_rst_reg[SOFT_RST_BIT];
	assign eng_restart = tst_rst || restart_reg;
	assign mode = ber_mode_e'(ctrl1_reg[MODE_LSB +: MODE_W]);

	// ==========================================================
	// Transmit insertion
	assign tx_pick = tx_in_i.strobe && tx_ctrl_reg[PORT_EN_BIT] && tx_sel_reg[tx_in_i.slot]
		&& !tx_supp_reg[tx_in_i.pos];

	ber_pattern_engine #(.PAT_W(32)) u_tx_gen (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.restart_i(eng_restart),
		.advance_i(tx_pick),
		.load_i(1'b0),
		.load_bit_i(1'b0),
		.mode_i(mode),
		.pattern_i(pat_reg),
		.len_m1_i(ctrl2_reg[LEN_W-1:0]),
		.alt_count_i(alt_reg),
		.bit_o(tx_bit)
	);

	// Unpicked bits pass through; one cycle of latency either way
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			tx_out_o <= '0;
		else begin
			tx_out_o <= tx_in_i;
			if (tx_pick)
				tx_out_o.data <= tx_bit;
		end
	end

	// ==========================================================
	// Receive checker
	assign rx_pick = rx_in_i.strobe && rx_ctrl_reg[PORT_EN_BIT] && rx_sel_reg[rx_in_i.slot]
		&& !rx_supp_reg[rx_in_i.pos];
	assign rx_err = rx_pick && (rx_in_i.data != rx_bit);
	assign locked = sync_reg == S_LOCKED;
	assign lfsr_mode = mode <= M_QRSS;
	// While hunting a fixed pattern a miss holds the pointer, slipping one bit
	assign rx_adv = rx_pick && (locked || lfsr_mode || !rx_err);
	assign rx_load = !locked && lfsr_mode;

	ber_pattern_engine #(.PAT_W(32)) u_rx_ref (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.restart_i(eng_restart),
		.advance_i(rx_adv),
		.load_i(rx_load),
		.load_bit_i(rx_in_i.data),
		.mode_i(mode),
		.pattern_i(pat_reg),
		.len_m1_i(ctrl2_reg[LEN_W-1:0]),
		.alt_count_i(alt_reg),
		.bit_o(rx_bit)
	);

	// Sync: a run of good bits locks, too many errors in one window drops lock
	always_comb begin
		sync_next = sync_reg;
		case (sync_reg)
			S_HUNT:
				if (rx_pick && !rx_err && run_reg == SYNC_LAST)
					sync_next = S_LOCKED;
			S_LOCKED:
				if (rx_err && loss_reg == LOSS_LAST)
					sync_next = S_HUNT;
			default: sync_next = S_HUNT;
		endcase
		if (restart_reg)
			sync_next = S_HUNT;
	end

	always_ff @(posedge ref_clk_i) begin
		if (tst_rst)
			sync_reg <= S_HUNT;
		else
			sync_reg <= sync_next;
	end

	// Match run, error window and loss counters restart on every sync change
	always_ff @(posedge ref_clk_i) begin
		if (tst_rst || sync_next != sync_reg) begin
			run_reg <= '0;
			win_reg <= '0;
			loss_reg <= '0;
		end else if (rx_pick) begin
			run_reg <= rx_err ? '0 : run_reg + 6'h01;
			win_reg <= (win_reg == WIN_LAST) ? '0 : win_reg + 6'h01;
			loss_reg <= (win_reg == WIN_LAST) ? '0 : loss_reg + rx_err;
		end
	end

	// Stuck-line detector for all zeros and all ones, raw data
	assign stuck_hit = rx_pick && rx_in_i.data == last_bit_reg && stuck_reg == STUCK_LAST;
	always_ff @(posedge ref_clk_i) begin
		if (tst_rst) begin
			stuck_reg <= '0;
			last_bit_reg <= 1'b0;
		end else if (rx_pick) begin
			last_bit_reg <= rx_in_i.data;
			if (rx_in_i.data != last_bit_reg)
				stuck_reg <= 6'h01;
			else if (stuck_reg != STUCK_FULL)
				stuck_reg <= stuck_reg + 6'h01;
		end
	end

	// ==========================================================
	// Counters; a latch-bit toggle snapshots them for reading and clears them
	assign lc_tog = ctrl1_reg[LC_BIT] != lc_prev_reg;
	assign cnt_bit = rx_pick && locked;
	assign cnt_err = cnt_bit && rx_err;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			lc_prev_reg <= 1'b0;
		else
			lc_prev_reg <= ctrl1_reg[LC_BIT];
	end

	always_ff @(posedge ref_clk_i) begin
		if (tst_rst) begin
			bit_cnt_reg <= '0;
			err_cnt_reg <= '0;
			bit_snap_reg <= '0;
			err_snap_reg <= '0;
		end else if (lc_tog) begin
			bit_snap_reg <= bit_cnt_reg;
			err_snap_reg <= err_cnt_reg;
			bit_cnt_reg <= '0;
			err_cnt_reg <= '0;
		end else begin
			if (cnt_bit && bit_cnt_reg != BIT_MAX)
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			if (cnt_err && err_cnt_reg != ERR_MAX)
				err_cnt_reg <= err_cnt_reg + 1'b1;
		end
	end

	// ==========================================================
	// Events and latched status; a set in the clearing cycle wins
	assign ev[EV_SYNC] = sync_next != sync_reg;
	assign ev[EV_ZEROS] = stuck_hit && !rx_in_i.data;
	assign ev[EV_ONES] = stuck_hit && rx_in_i.data;
	assign ev[EV_ERR_OVF] = cnt_err && !lc_tog && err_cnt_reg == ERR_NEAR;
	assign ev[EV_BIT_OVF] = cnt_bit && !lc_tog && bit_cnt_reg == BIT_NEAR;
	assign ev[EV_BIT_ERR] = cnt_err;
	assign clr_v = (wr_i && addr_i == A_LATCHED) ? wdata_i[NUM_EV-1:0] : '0;
	assign keep_v = latched_reg & ~clr_v;

	always_ff @(posedge ref_clk_i) begin
		if (tst_rst)
			latched_reg <= '0;
		else
			latched_reg <= keep_v | ev;
	end

	// Summary follows unmasked latched bits with no storage of its own
	assign gstat = |(latched_reg & stat_mask_reg);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			global_event_o <= 1'b0;
			rx_in_sync_o <= 1'b0;
		end else begin
			global_event_o <= gstat && girq_mask_reg[GIRQ_BIT];
			rx_in_sync_o <= locked;
		end
	end

	// ==========================================================
	// Read port: data in the cycle after the strobe, zero otherwise
	assign bit_rd = 32'(bit_snap_reg);
	assign err_rd = 32'(err_snap_reg);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !rd_i)
			rdata_o <= '0;
		else if (hit(A_PATTERN, SPAN4))
			rdata_o <= pat_reg[{byte_idx(A_PATTERN), 3'b000} +: DATA_W];
		else if (hit(A_RX_CH_SEL, SPAN4))
			rdata_o <= rx_sel_reg[{byte_idx(A_RX_CH_SEL), 3'b000} +: DATA_W];
		else if (hit(A_TX_CH_SEL, SPAN4))
			rdata_o <= tx_sel_reg[{byte_idx(A_TX_CH_SEL), 3'b000} +: DATA_W];
		else if (hit(A_BIT_COUNT, SPAN4))
			rdata_o <= bit_rd[{byte_idx(A_BIT_COUNT), 3'b000} +: DATA_W];
		else if (hit(A_ERR_COUNT, SPAN3))
			rdata_o <= err_rd[{byte_idx(A_ERR_COUNT), 3'b000} +: DATA_W];
		else begin
			case (addr_i)
				A_SOFT_RESET: rdata_o <= soft_rst_reg;
				A_GIRQ_STATUS: rdata_o <= DATA_W'(gstat);
				A_GIRQ_MASK: rdata_o <= girq_mask_reg;
				A_RX_PORT_CTRL: rdata_o <= rx_ctrl_reg;
				A_RX_BIT_SUPP: rdata_o <= rx_supp_reg;
				A_TX_PORT_CTRL: rdata_o <= tx_ctrl_reg;
				A_TX_BIT_SUPP: rdata_o <= tx_supp_reg;
				A_ALT_COUNT: rdata_o <= alt_reg;
				A_CTRL_ONE: rdata_o <= ctrl1_reg;
				A_CTRL_TWO: rdata_o <= ctrl2_reg;
				A_LATCHED: rdata_o <= DATA_W'({locked, latched_reg});
				A_STAT_MASK: rdata_o <= DATA_W'(stat_mask_reg);
				default: rdata_o <= '0;
			endcase
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_lc_toggle;
		lc_tog && !tst_rst;
	endsequence
	sequence s_err_reach;
		err_cnt_reg != ERR_MAX ##1 err_cnt_reg == ERR_MAX;
	endsequence

	property p_err_sat;
		err_cnt_reg == ERR_MAX && !lc_tog && !tst_rst |=> err_cnt_reg == ERR_MAX;
	endproperty
	a_err_sat: assert property (p_err_sat) else $error("error counter wrapped");
	property p_ovf_flag;
		s_err_reach |-> latched_reg[EV_ERR_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");
	property p_err_locked;
		err_cnt_reg > $past(err_cnt_reg) |-> $past(sync_reg) == S_LOCKED && $past(rx_err);
	endproperty
	a_err_locked: assert property (p_err_locked) else $error("error counted out of sync");
	property p_lc_clear;
		s_lc_toggle |=> err_cnt_reg == '0 && bit_cnt_reg == '0;
	endproperty
	a_lc_clear: assert property (p_lc_clear) else $error("latch toggle did not clear");
	property p_w1c;
		!tst_rst |=> (latched_reg & $past(clr_v) & ~$past(ev)) == '0;
	endproperty
	a_w1c: assert property (p_w1c) else $error("written one did not clear");
	property p_w0_keep;
		!tst_rst |=> (latched_reg & $past(keep_v)) == $past(keep_v);
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("latched bit lost");
	property p_masked;
		(latched_reg & stat_mask_reg) == '0 |=> !global_event_o;
	endproperty
	a_masked: assert property (p_masked) else $error("masked event reached summary");
	property p_summary;
		gstat && girq_mask_reg[GIRQ_BIT] |=> global_event_o;
	endproperty
	a_summary: assert property (p_summary) else $error("summary did not follow");
	property p_sync_evt;
		!tst_rst ##1 sync_reg != $past(sync_reg) |-> latched_reg[EV_SYNC];
	endproperty
	a_sync_evt: assert property (p_sync_evt) else $error("sync change not latched");
	property p_tx_insert;
		tx_pick |=> tx_out_o.data == $past(tx_bit) && tx_out_o.strobe;
	endproperty
	a_tx_insert: assert property (p_tx_insert) else $error("pattern bit not inserted");
	property p_tx_pass;
		tx_in_i.strobe && !tx_pick |=> tx_out_o.data == $past(tx_in_i.data);
	endproperty
	a_tx_pass: assert property (p_tx_pass) else $error("unpicked bit altered");
endmodule

// ---- sim/ber_framer_model.sv ----
// Framer stand-in: timeslot bit stream out, receive path looped back
`timescale 1ns/1ps
module ber_framer_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Loop control
	input wire logic flip_i,
	input wire ber_pkg::ber_slot_bit_s tx_out_i,
	// Streams toward the tester
	output ber_pkg::ber_slot_bit_s tx_in_o,
	output ber_pkg::ber_slot_bit_s rx_in_o
);
	import ber_pkg::*;
	logic [1:0] gap_reg = 2'h0;
	logic pend_reg = 1'b0;

	// ==========
	// Transmit stream
	initial tx_in_o = '0;
	// Every fourth cycle carries no bit; data toggles so stale values show
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			gap_reg <= 2'h0;
			tx_in_o <= '0;
		end else begin
			gap_reg <= gap_reg + 2'h1;
			tx_in_o.strobe <= gap_reg != 2'h3;
			tx_in_o.data <= ~tx_in_o.data;
			if (tx_in_o.strobe)
				{tx_in_o.slot, tx_in_o.pos} <= {tx_in_o.slot, tx_in_o.pos} + 8'h01;
		end
	end

	// ==========
	// Receive loop
	// A flip request waits for the next bit really carried, so one error lands
	always @(posedge ref_clk_i) begin
		pend_reg <= !reset_i && (flip_i || (pend_reg && !tx_out_i.strobe));
	end
	always_comb begin
		rx_in_o = tx_out_i;
		rx_in_o.data = tx_out_i.data ^ (pend_reg & tx_out_i.strobe);
	end
endmodule

// ---- sim/bit_error_rate_tester_tb.sv ----
// Self-checking bench of the bit error rate tester
`timescale 1ns/1ps
module bit_error_rate_tester_tb;
	import ber_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	ber_addr_t addr_i = '0;
	ber_byte_t wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic flip = 1'b0;
	ber_byte_t rdata_o;
	ber_byte_t v;
	ber_slot_bit_s tx_in, tx_out, rx_in, tx_prev;
	logic in_sync, gev;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;

	// ==========
	// Design and framer
	// Small counter widths let both overflows happen in a short run
	ber_tester #(.BIT_CNT_W(8), .ERR_CNT_W(4)) dut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .tx_in_i(tx_in), .tx_out_o(tx_out), .rx_in_i(rx_in),
		.rx_in_sync_o(in_sync), .global_event_o(gev));
	ber_framer_model frm (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .flip_i(flip),
		.tx_out_i(tx_out), .tx_in_o(tx_in), .rx_in_o(rx_in));

	// ==========
	// Clock, input copy, time limit
	initial forever #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) tx_prev <= tx_in;
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ==========
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input ber_addr_t a, input ber_byte_t d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// Bytes go little-endian over consecutive addresses
	task automatic wr4(input ber_addr_t a, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			wr(a + ber_addr_t'(i), d[8*i+:8]);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input ber_addr_t a, input ber_byte_t m, input ber_byte_t e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata_o;
		check(v & m, e);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========
	// Tests
	initial begin
		repeat (10) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		// Reset values, a read-only place, an unmapped place
		rdc(A_PATTERN, 8'hff, 8'hff);
		rdc(A_CTRL_TWO, 8'hff, 8'h1f);
		wr(A_GIRQ_STATUS, 8'hff);
		rdc(A_GIRQ_STATUS, 8'hff, 8'h00);
		wr(13'h1010, 8'h00);
		rdc(13'h1010, 8'hff, 8'h00);
		$display("test reset done");
		// Five-bit pattern in slot 0 only, bit position 7 left alone
		wr(A_TX_BIT_SUPP, 8'h80);
		wr(A_TX_CH_SEL, 8'h01);
		wr(A_TX_PORT_CTRL, 8'h01);
		wr4(A_PATTERN, 32'h5ad6b5ad);
		wr(A_CTRL_TWO, 8'h04);
		// Restart while slot 16 passes, so the next slot 0 meets pointer 0
		do @(negedge ref_clk_i); while (tx_prev.slot != 5'd16 || tx_prev.pos != 3'd0);
		wr(A_CTRL_ONE, 8'h14);
		k = 0;
		repeat (1400) begin
			@(negedge ref_clk_i);
			if (tx_prev.strobe && tx_prev.slot == 5'd0 && tx_prev.pos != 3'd7) begin
				check(tx_out.data, 1'(5'h0d >> (k % 5)));
				k++;
			end else
				check(tx_out, tx_prev);
		end
		$display("test insertion done");
		// Loop all slots, inject spaced errors until the counter saturates
		wr4(A_TX_CH_SEL, 32'hffffffff);
		wr(A_TX_BIT_SUPP, 8'h00);
		wr4(A_RX_CH_SEL, 32'hffffffff);
		wr(A_RX_PORT_CTRL, 8'h01);
		wr(A_STAT_MASK, 8'h20);
		wr(A_GIRQ_MASK, 8'h01);
		wr(A_CTRL_ONE, 8'h14);
		repeat (120) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check(in_sync, 1'b1);
		rdc(A_LATCHED, 8'h21, 8'h01);
		repeat (17) begin
			flip <= 1'b1;
			@(posedge ref_clk_i);
			flip <= 1'b0;
			repeat (60) @(posedge ref_clk_i);
		end
		@(negedge ref_clk_i);
		check(gev, 1'b1);
		rdc(A_GIRQ_STATUS, 8'h01, 8'h01);
		wr(A_CTRL_ONE, 8'h15);
		rdc(A_ERR_COUNT, 8'hff, 8'h0f);
		rdc(A_LATCHED, 8'h28, 8'h28);
		wr(A_LATCHED, 8'h00);
		rdc(A_LATCHED, 8'h20, 8'h20);
		wr(A_LATCHED, 8'h20);
		rdc(A_LATCHED, 8'h20, 8'h00);
		@(negedge ref_clk_i);
		check(gev, 1'b0);
		$display("test errors done");
		// Every pattern mode reaches lock over the loop
		wr4(A_PATTERN, 32'hffffffff);
		wr(A_ALT_COUNT, 8'h01);
		for (int m = 0; m < 8; m++) begin
			wr(A_CTRL_ONE, 8'(m * 4 + 1));
			repeat (200) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			check(in_sync, 1'b1);
		end
		rdc(A_LATCHED, 8'h54, 8'h54);
		$display("test modes done");
		print_verdict();
	end
endmodule
